// *** exec_unit_consts.svh ***
`ifndef EXEC_UNIT_CONSTS_SVH
`define EXEC_UNIT_CONSTS_SVH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NONE 3'h0
`define OP_SUM_CARRY_TO_WORK 3'h1
`define OP_SUM_CARRY_TO_MEM 3'h2
`define OP_SUM_TO_WORK 3'h3
`define OP_SUM_IMM_TO_WORK 3'h4
`define OP_SUM_TO_MEM 3'h5
`define OP_AND_TO_MEM 3'h6

// ----------------------------------------
// Bit positions and reset values
// ----------------------------------------
`define HALF_BIT 4
`define WORK_RESET 8'h00

`endif

// *** exec_unit_pkg.sv ***
package exec_unit_pkg;
  typedef logic [2:0] op_code_t;

  typedef struct packed {
    logic [8:0] sum;
    logic half;
    logic overflow;
  } sum_out_t;

  typedef struct packed {
    logic [7:0] working_register;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic [7:0] flag_data;
    logic [3:0] flag_we;
    logic done;
  } exec_state_t;
endpackage

// *** byte_adder.sv ***
`timescale 1ns/100ps
`include "exec_unit_consts.svh"

// ----------------------------------------
// Eight-bit adder with flag terms
// ----------------------------------------
module byte_adder
  import exec_unit_pkg::*;
(
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  // Result
  output sum_out_t result
);
  logic [4:0] low_sum;

  // Low nibble gives the half carry out of bit 3
  always_comb begin
    low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    result.sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    result.half = low_sum[`HALF_BIT];
    // Overflow: equal operand signs, result sign differs
    result.overflow = (a[7] == b[7]) && (result.sum[7] != a[7]);
  end
endmodule

// *** add_and_logic_execute_unit.sv ***
`timescale 1ns/100ps
`include "exec_unit_consts.svh"

module add_and_logic_execute_unit
  import exec_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Decoder request
  input wire logic op_valid,
  input wire op_code_t op_code,
  input wire logic [7:0] imm_data,
  // Data memory operand and write back
  input wire logic [7:0] mem_rdata,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  // Status flags in and out
  input wire logic carry_flag,
  output logic carry_flag_out,
  output logic half_carry_flag,
  output logic signed_range_flag,
  output logic null_flag,
  output logic [3:0] flag_we,
  // Working register and completion
  output logic [7:0] working_register,
  output logic done
);
  // flag_we bit order: {signed_range, null, half_carry, carry}
  exec_state_t state;
  exec_state_t next_state;
  logic [7:0] add_b;
  logic add_cin;
  sum_out_t add_out;
  logic [7:0] and_res;

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  // Immediate form swaps in the instruction byte; carry only for carry ops
  always_comb begin
    add_b = (op_code == `OP_SUM_IMM_TO_WORK) ? imm_data : mem_rdata;
    add_cin = ((op_code == `OP_SUM_CARRY_TO_WORK) ||
               (op_code == `OP_SUM_CARRY_TO_MEM)) ? carry_flag : 1'b0;
  end

  byte_adder i_byte_adder (
    .a(state.working_register),
    .b(add_b),
    .cin(add_cin),
    .result(add_out)
  );

  assign and_res = state.working_register & mem_rdata;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Strobes last one cycle; working register holds unless written
  always_comb begin
    next_state = state;
    next_state.mem_we = 1'b0;
    next_state.flag_we = 4'h0;
    next_state.done = 1'b0;
    if (op_valid) begin
      next_state.done = 1'b1;
      // Flags from one adder shared by all sums
      next_state.flag_data = {4'h0, add_out.overflow,
                              add_out.sum[7:0] == 8'h00,
                              add_out.half, add_out.sum[8]};
      case (op_code)
        `OP_SUM_CARRY_TO_WORK, `OP_SUM_TO_WORK, `OP_SUM_IMM_TO_WORK: begin
          next_state.working_register = add_out.sum[7:0];
          next_state.flag_we = 4'hF;
        end
        `OP_SUM_CARRY_TO_MEM, `OP_SUM_TO_MEM: begin
          next_state.mem_wdata = add_out.sum[7:0];
          next_state.mem_we = 1'b1;
          next_state.flag_we = 4'hF;
        end
        `OP_AND_TO_MEM: begin
          next_state.mem_wdata = and_res;
          next_state.mem_we = 1'b1;
          next_state.flag_data = {4'h0, 1'b0, and_res == 8'h00, 2'h0};
          next_state.flag_we = 4'h4;
        end
        default: begin
          // Unknown codes retire with no write strobe, though the flag outputs still take the adder terms
          next_state.done = 1'b1;
        end
      endcase
    end
  end

  // Single register stage for the whole state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
      state.working_register <= `WORK_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign working_register = state.working_register;
  assign mem_wdata = state.mem_wdata;
  assign mem_we = state.mem_we;
  assign flag_we = state.flag_we;
  assign done = state.done;
  assign signed_range_flag = state.flag_data[3];
  assign null_flag = state.flag_data[2];
  assign half_carry_flag = state.flag_data[1];
  assign carry_flag_out = state.flag_data[0];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Reference sums built apart from the shared adder, read through $past
  logic chk_carry_op;
  logic [7:0] chk_b;
  logic [8:0] chk_sum;
  logic [4:0] chk_low;
  logic [8:0] chk_signed;

  // Sign-extended sum: overflow shows as bits 8 and 7 disagreeing
  always_comb begin
    chk_carry_op = (op_code == `OP_SUM_CARRY_TO_WORK) ||
                   (op_code == `OP_SUM_CARRY_TO_MEM);
    chk_b = (op_code == `OP_SUM_IMM_TO_WORK) ? imm_data : mem_rdata;
    chk_sum = {1'b0, state.working_register} + {1'b0, chk_b} +
              {8'h00, chk_carry_op & carry_flag};
    chk_low = {1'b0, state.working_register[3:0]} + {1'b0, chk_b[3:0]} +
              {4'h0, chk_carry_op & carry_flag};
    chk_signed = {state.working_register[7], state.working_register} +
                 {chk_b[7], chk_b} + {8'h00, chk_carry_op & carry_flag};
  end

  AST_CARRY_TO_WORK: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_SUM_CARRY_TO_WORK |=>
      working_register == $past(chk_sum[7:0]) &&
      carry_flag_out == $past(chk_sum[8]) && flag_we == 4'hF && !mem_we)
    else $error("carry sum into work wrong");

  AST_CARRY_TO_MEM: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_SUM_CARRY_TO_MEM |=>
      mem_we && mem_wdata == $past(chk_sum[7:0]) && flag_we == 4'hF &&
      $stable(working_register))
    else $error("carry sum into memory wrong");

  AST_SUM_TO_WORK: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_SUM_TO_WORK |=>
      working_register ==
        8'($past(state.working_register) + $past(mem_rdata)) &&
      !mem_we && flag_we == 4'hF)
    else $error("sum into work wrong");

  AST_SUM_IMM: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_SUM_IMM_TO_WORK |=>
      working_register ==
        8'($past(state.working_register) + $past(imm_data)))
    else $error("immediate sum wrong");

  AST_SUM_TO_MEM: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_SUM_TO_MEM |=>
      mem_we && $stable(working_register) && flag_we == 4'hF &&
      mem_wdata == 8'($past(state.working_register) + $past(mem_rdata)))
    else $error("sum into memory wrong");

  AST_AND_TO_MEM: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_AND_TO_MEM |=>
      mem_we && flag_we == 4'h4 && null_flag == (mem_wdata == 8'h00) &&
      mem_wdata == ($past(state.working_register) & $past(mem_rdata)))
    else $error("and into memory wrong");

  AST_NULL_FLAG: assert property (
    @(posedge clk) disable iff (!resetn)
    flag_we == 4'hF |-> null_flag == ((mem_we ? mem_wdata :
      working_register) == 8'h00))
    else $error("null flag mismatch");

  AST_STROBE_ONE: assert property (
    @(posedge clk) disable iff (!resetn)
    !op_valid |=> !mem_we && flag_we == 4'h0 && !done)
    else $error("strobe without request");

  // Carry terms from the reference sums, not from the shared adder
  AST_HALF_AND_CARRY: assert property (
    @(posedge clk) disable iff (!resetn)
    flag_we == 4'hF |->
      half_carry_flag == $past(chk_low[4]) &&
      carry_flag_out == $past(chk_sum[8]))
    else $error("half carry or carry flag wrong");

  AST_SIGNED_RANGE: assert property (
    @(posedge clk) disable iff (!resetn)
    flag_we == 4'hF |->
      signed_range_flag == ($past(chk_signed[8]) != $past(chk_signed[7])))
    else $error("signed range flag wrong");

  // AND writes memory and the null flag; the working register must not move
  AST_AND_KEEPS_WORK: assert property (
    @(posedge clk) disable iff (!resetn)
    op_valid && op_code == `OP_AND_TO_MEM |=>
      $stable(working_register) && done)
    else $error("and changed the working register");

  // Idle cycles leave the working register alone
  AST_IDLE_HOLD: assert property (
    @(posedge clk) disable iff (!resetn)
    !op_valid |=> $stable(working_register))
    else $error("working register moved while idle");

  // Main scenarios worth seeing at least once
  COV_CARRY_OUT: cover property (@(posedge clk)
    carry_flag_out && flag_we[0]);
  COV_OVERFLOW: cover property (@(posedge clk)
    signed_range_flag && flag_we[3]);
  COV_AND_ZERO: cover property (@(posedge clk)
    flag_we == 4'h4 && null_flag);
  COV_HALF_CARRY: cover property (@(posedge clk)
    half_carry_flag && flag_we[1]);
  COV_BACK_TO_BACK: cover property (@(posedge clk)
    op_valid ##1 op_valid);
endmodule

// *** flag_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// Status register stand-in, carry only
// ----------------------------------------
module flag_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Carry write from the unit
  input wire logic carry_in,
  input wire logic carry_we,
  // Carry seen by the unit
  output logic carry
);
  logic stored;

  // Bypass, so a back-to-back request sees the fresh carry
  assign carry = carry_we ? carry_in : stored;

  // Holds the last written carry
  always_ff @(posedge clk) begin
    if (!resetn)
      stored <= 1'b0;
    else if (carry_we)
      stored <= carry_in;
  end
endmodule

// *** tb_add_and_logic_execute_unit.sv ***
`timescale 1ns/100ps
`include "exec_unit_consts.svh"

module tb_add_and_logic_execute_unit
  import exec_unit_pkg::*;
();
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  op_code_t op_code = 3'h0;
  logic [7:0] imm_data = 8'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic carry_flag, carry_flag_out, half_carry_flag, signed_range_flag;
  logic null_flag, mem_we, done;
  logic [7:0] mem_wdata, working_register, m, w = 8'h00;
  logic [3:0] flag_we;
  logic [25:0] q[$];
  logic [25:0] exp_v, got, rst_seen;
  logic [31:0] rnd = 32'h000153F0;
  logic [2:0] o;
  logic c = 1'b0;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  add_and_logic_execute_unit i_add_and_logic_execute_unit (.clk(clk),
    .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .imm_data(imm_data), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .carry_flag(carry_flag),
    .carry_flag_out(carry_flag_out), .half_carry_flag(half_carry_flag),
    .signed_range_flag(signed_range_flag), .null_flag(null_flag),
    .flag_we(flag_we), .working_register(working_register), .done(done));

  flag_model i_flag_model (.clk(clk), .resetn(resetn),
    .carry_in(carry_flag_out), .carry_we(flag_we[0]), .carry(carry_flag));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Reference result of one request, noted in issue order
  task automatic note(input logic [2:0] k, input logic [7:0] d,
                      input logic [7:0] i);
    logic [7:0] b, nw;
    logic ci, h, v, we;
    logic [8:0] s;
    b = (k == `OP_SUM_IMM_TO_WORK) ? i : d;
    ci = (k == `OP_SUM_CARRY_TO_WORK || k == `OP_SUM_CARRY_TO_MEM) & c;
    s = {1'b0, w} + {1'b0, b} + {8'h00, ci};
    h = ({1'b0, w[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F;
    v = (w[7] == b[7]) && (s[7] != w[7]);
    we = (k == `OP_SUM_CARRY_TO_MEM || k == `OP_SUM_TO_MEM);
    nw = we ? w : s[7:0];
    if (k == `OP_AND_TO_MEM) begin
      s[7:0] = w & d;
      q.push_back({1'b1, w, 1'b1, s[7:0], 4'h4, 1'b0, s[7:0] == 8'h00,
                   2'b00});
    end else if (k == 3'h7) begin
      q.push_back({1'b1, w, 17'h00000});
    end else begin
      q.push_back({1'b1, nw, we, we ? s[7:0] : 8'h00, 4'hF, v,
                   s[7:0] == 8'h00, h, s[8]});
      w = nw;
      c = s[8];
    end
  endtask

  task automatic results;
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Stimulus: random ops, some forced to a zero sum
  // ----------------------------------------
  // One run of n random cycles, a request in about three of four, then a drain and a pending check
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk);
      rnd = xs(rnd);
      o = 3'h1 + rnd[10:8] % 3'h7;
      m = (rnd[7:5] == 3'h0) ? 8'h00 - w : rnd[23:16];
      op_valid <= rnd[0] | rnd[1];
      op_code <= o;
      mem_rdata <= m;
      imm_data <= (rnd[7:5] == 3'h0) ? 8'h00 - w : rnd[31:24];
      if (rnd[0] | rnd[1])
        note(o, m, (rnd[7:5] == 3'h0) ? 8'h00 - w : rnd[31:24]);
    end
    @(posedge clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check_count++;
    if (q.size() != 0) begin
      fails++;
      $display("unexpected pending exp 0 got %0d", q.size());
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    burst(600);
    // Mid-run reset: every output back to zero, model restarts too
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_seen = {done, working_register, mem_we, mem_wdata, flag_we,
                signed_range_flag, null_flag, half_carry_flag,
                carry_flag_out};
    check_count++;
    if (rst_seen !== 26'h0000000) begin
      fails++;
      $display("unexpected reset state exp 0000000 got %h", rst_seen);
    end
    @(posedge clk);
    resetn <= 1'b1;
    w = 8'h00;
    c = 1'b0;
    burst(100);
    results();
  end

  // ----------------------------------------
  // Monitor: strobes always come with a noted request
  // ----------------------------------------
  always @(negedge clk) begin
    if (resetn && (done || mem_we || flag_we != 4'h0)) begin
      got = {done, working_register, mem_we, mem_we ? mem_wdata : 8'h00,
             flag_we, flag_we & {signed_range_flag, null_flag,
             half_carry_flag, carry_flag_out}};
      exp_v = (q.size() > 0) ? q.pop_front() : 26'h0;
      check_count++;
      if (got !== exp_v) begin
        fails++;
        $display("unexpected result exp %h got %h", exp_v, got);
      end
    end
  end

  // Hang guard, well above the 723 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      results();
    end
  end
endmodule
